// File: verilog/ips_pkg.sv
// package: constants and types for the input power-up sequencer
package ips_pkg;

  // ==========================================================================
  // clock and times
  localparam int CLK_HZ       = 20_000_000;
  localparam int T_BAD_SRC_MS = 30;
  localparam int T_BIAS_MS    = 220;
  localparam int T_DISCHG_MS  = 13;
  localparam int T_SS_US      = 100;
  localparam int T_INT_NS     = 1000;
  localparam int BAD_SRC_CYC  = CLK_HZ / 1000 * T_BAD_SRC_MS;
  localparam int BIAS_CYC     = CLK_HZ / 1000 * T_BIAS_MS;
  localparam int DISCHG_CYC   = CLK_HZ / 1000 * T_DISCHG_MS;
  localparam int SS_CYC       = CLK_HZ / 1_000_000 * T_SS_US;
  localparam int INT_CYC      = CLK_HZ / 1_000_000 * T_INT_NS / 1000;
  localparam logic [2:0] MAX_FAILS = 3'h7;

  // ==========================================================================
  // register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LIM_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [8:0] CTRL_RST = 9'h086;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ==========================================================================
  // current limit codes (100 mA per step) and source status codes
  localparam logic [4:0] EXTERNAL_CURRENT_LIMIT_PIN_0P5A = 5'h05;
  localparam logic [4:0] EXTERNAL_CURRENT_LIMIT_PIN_1P0A = 5'h0a;
  localparam logic [4:0] EXTERNAL_CURRENT_LIMIT_PIN_1P5A = 5'h0f;
  localparam logic [4:0] EXTERNAL_CURRENT_LIMIT_PIN_2P1A = 5'h15;
  localparam logic [4:0] EXTERNAL_CURRENT_LIMIT_PIN_2P4A = 5'h18;
  localparam logic [4:0] EXTERNAL_CURRENT_LIMIT_PIN_3P0A = 5'h1e;
  localparam logic [4:0] EXTERNAL_CURRENT_LIMIT_PIN_RST  = EXTERNAL_CURRENT_LIMIT_PIN_0P5A;
  localparam logic [4:0] VLIM_RST  = 5'h06;
  localparam logic [2:0] STAT_NONE = 3'h0;
  localparam logic [2:0] STAT_SDP  = 3'h1;
  localparam logic [2:0] STAT_CDP  = 3'h2;
  localparam logic [2:0] STAT_DCP  = 3'h3;
  localparam logic [2:0] STAT_UNK  = 3'h5;
  localparam logic [2:0] STAT_DIV  = 3'h6;

  // ==========================================================================
  // types
  typedef enum logic [11:0] {
    ST_IDLE = 12'h001, ST_QUAL = 12'h002, ST_OVW  = 12'h004,
    ST_HIZ  = 12'h008, ST_VDET = 12'h010, ST_DCD  = 12'h020,
    ST_PRI  = 12'h040, ST_SEC  = 12'h080, ST_DONE = 12'h100,
    ST_BIAS = 12'h200, ST_CONV = 12'h400, ST_RUN  = 12'h800
  } ips_state_e;

  typedef struct packed {
    logic [4:0] ext_external_current_limit_pin;
    logic       vbus_present;
    logic       vbus_ov;
    logic       vbus_bad;
    logic       bat_ok;
    logic       dcd_ok;
    logic       pri_hit;
    logic       sec_dcp;
    logic       dp_hi;
    logic       dp_mid;
    logic       dm_hi;
    logic       dm_mid;
    logic       dp_pull_low;
    logic       dm_3v3;
    logic       light_load;
    logic       bat_below_sysmin;
  } ips_pin_s;

  typedef struct packed {
    logic host_mode;
    logic charge_enable;
    logic audible_floor_disable;
    logic pulse_skip_disable;
    logic battery_discharge_enable;
    logic force_source_detect;
    logic voltage_limit_reload_enable;
    logic auto_source_detect_enable;
    logic high_impedance_enable;
  } ips_ctl_s;

  typedef struct packed {
    ips_state_e  st;
    logic [22:0] tmr;
    logic [2:0]  fails;
    logic [18:0] dcnt;
    logic [4:0]  icnt;
    ips_ctl_s    ctl;
    logic [4:0]  external_current_limit_pin;
    logic [4:0]  vlim;
    logic [2:0]  vstat;
    logic        pg;
    logic        pgf;
    logic        forced;
    logic        ran;
    logic [4:0]  rilim;
    logic [2:0]  rstat;
    logic        hizp;
    logic        vbp;
    ips_pin_s    s1;
    ips_pin_s    s2;
    ips_pin_s    s3;
    ips_pin_s    f;
    logic        batsw;
    logic        bias;
    logic        conv;
    logic        ss;
    logic        disld;
    logic        bsload;
    logic [4:0]  apilim;
    logic        pskip;
    logic        afl;
    logic        awh;
    logic [7:0]  awa;
    logic        wh;
    logic [31:0] wd;
    logic [3:0]  ws;
    logic        bv;
    logic [1:0]  bresp;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  rresp;
  } ips_reg_s;

endpackage

// File: verilog/ips_seq.sv
// module: input power-up sequencer with its register slave
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module ips_seq
  import ips_pkg::*;
#(
  parameter int P_BAD_SRC_CYC = BAD_SRC_CYC,
  parameter int P_BIAS_CYC    = BIAS_CYC,
  parameter int P_DISCHG_CYC  = DISCHG_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire ips_pin_s    pins,
  output logic             battery_switch_on,
  output logic             bias_regulator_en,
  output logic             converter_en,
  output logic             soft_start,
  output logic             bad_source_load_en,
  output logic             discharge_load_en,
  output logic             pulse_skip_en,
  output logic             audible_floor_en,
  output logic [4:0]       applied_current_limit,
  output logic [2:0]       source_type_status,
  output logic             power_good_pin_n,
  output logic             interrupt_pulse_pin_n
);

  // ==========================================================================
  // helpers
  function automatic logic [31:0] wmerge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0]  s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [4:0] imin(input logic [4:0] a,
                                      input logic [4:0] b);
    return (a < b) ? a : b;
  endfunction

  ips_reg_s    r;
  ips_reg_s    n;
  logic        vb;
  logic        wr;
  logic        wr_ctrl;
  logic        off_st;
  logic [31:0] lim_m;

  // ==========================================================================
  // next state
  always_comb begin
    n = r;
    // pin synchroniser, value taken when second and third agree
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    if (r.s2 == r.s3) begin
      n.f = r.s3;
    end
    // register slave
    if (s_axi_awvalid && !r.awh && !r.bv) begin
      n.awh = 1'b1;
      n.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !r.wh && !r.bv) begin
      n.wh = 1'b1;
      n.wd = s_axi_wdata;
      n.ws = s_axi_wstrb;
    end
    wr      = r.awh && r.wh && !r.bv;
    wr_ctrl = wr && (r.awa == CTRL_OFS);
    lim_m   = wmerge({19'h0, r.vlim, 3'h0, r.external_current_limit_pin}, r.wd, r.ws);
    if (wr) begin
      n.awh   = 1'b0;
      n.wh    = 1'b0;
      n.bv    = 1'b1;
      n.bresp = RESP_OKAY;
      case (r.awa)
        CTRL_OFS: n.ctl = 9'(wmerge(32'(r.ctl), r.wd, r.ws));
        LIM_OFS: begin
          n.external_current_limit_pin = lim_m[4:0];
          n.vlim = lim_m[12:8];
        end
        STAT_OFS: begin
          if (r.ws[0] && r.wd[4]) begin
            n.pgf = 1'b0;
          end
        end
        default: n.bresp = RESP_DECERR;
      endcase
    end
    if (r.bv && s_axi_bready) begin
      n.bv = 1'b0;
    end
    if (s_axi_arvalid && !r.rv) begin
      n.rv    = 1'b1;
      n.rresp = RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFS: n.rd = {23'h0, r.ctl};
        LIM_OFS:  n.rd = {19'h0, r.vlim, 3'h0, r.external_current_limit_pin};
        STAT_OFS: n.rd = {12'h0, r.st, r.fails, r.pgf, r.pg, r.vstat};
        default: begin
          n.rd    = 32'h0;
          n.rresp = RESP_DECERR;
        end
      endcase
    end else if (r.rv && s_axi_rready) begin
      n.rv = 1'b0;
    end
    // sequencer
    vb    = r.f.vbus_present;
    n.vbp = vb;
    n.hizp = r.ctl.high_impedance_enable;
    if (vb && !r.vbp) begin
      n.ctl.high_impedance_enable = 1'b0;
    end
    n.tmr = r.tmr + 23'h1;
    case (r.st)
      ST_IDLE: begin
        if (vb) begin
          n.st = ST_QUAL;
        end
      end
      ST_QUAL: begin
        if (r.f.vbus_bad) begin
          n.tmr = '0;
          if (r.fails == MAX_FAILS - 3'h1) begin
            n.st    = ST_HIZ;
            n.fails = '0;
          end else begin
            n.fails = r.fails + 3'h1;
          end
        end else if (r.tmr == 23'(P_BAD_SRC_CYC - 1)) begin
          n.fails = '0;
          n.ran   = r.ctl.auto_source_detect_enable;
          n.st    = r.ctl.auto_source_detect_enable ? ST_VDET : ST_DONE;
        end
      end
      ST_OVW: begin
        if (!r.f.vbus_ov) begin
          n.st = ST_QUAL;
        end
      end
      ST_HIZ: begin
        if (r.hizp && !r.ctl.high_impedance_enable) begin
          n.st = ST_QUAL;
        end
      end
      ST_VDET: n.st = ST_DCD;
      ST_DCD: begin
        n.st = ST_DONE;
        if (r.f.dcd_ok) begin
          n.st = ST_PRI;
        end else if (r.f.dp_hi && r.f.dm_hi) begin
          n.rilim = EXTERNAL_CURRENT_LIMIT_PIN_2P4A;
          n.rstat = STAT_DIV;
        end else if (r.f.dp_hi && r.f.dm_mid) begin
          n.rilim = EXTERNAL_CURRENT_LIMIT_PIN_2P1A;
          n.rstat = STAT_DIV;
        end else if (r.f.dp_mid && r.f.dm_hi) begin
          n.rilim = EXTERNAL_CURRENT_LIMIT_PIN_1P0A;
          n.rstat = STAT_DIV;
        end else if (r.f.dp_pull_low && r.f.dm_3v3) begin
          n.rilim = EXTERNAL_CURRENT_LIMIT_PIN_1P0A;
          n.rstat = STAT_UNK;
        end else begin
          n.rilim = EXTERNAL_CURRENT_LIMIT_PIN_0P5A;
          n.rstat = STAT_UNK;
        end
      end
      ST_PRI: begin
        n.st    = r.f.pri_hit ? ST_SEC : ST_DONE;
        n.rilim = EXTERNAL_CURRENT_LIMIT_PIN_0P5A;
        n.rstat = STAT_SDP;
      end
      ST_SEC: begin
        n.st    = ST_DONE;
        n.rilim = r.f.sec_dcp ? EXTERNAL_CURRENT_LIMIT_PIN_3P0A : EXTERNAL_CURRENT_LIMIT_PIN_1P5A;
        n.rstat = r.f.sec_dcp ? STAT_DCP : STAT_CDP;
      end
      ST_DONE: begin
        if (r.ran) begin
          n.external_current_limit_pin  = r.rilim;
          n.vstat = r.rstat;
          if (r.ctl.voltage_limit_reload_enable) begin
            n.vlim = VLIM_RST;
          end
        end
        n.pg   = 1'b1;
        n.pgf  = 1'b1;
        n.icnt = 5'(INT_CYC);
        if (!wr_ctrl) begin
          n.ctl.force_source_detect = 1'b0;
        end
        n.forced = 1'b0;
        n.st     = r.forced ? ST_RUN : ST_BIAS;
      end
      ST_BIAS: begin
        if (r.tmr == 23'(P_BIAS_CYC - 1)) begin
          n.st   = ST_CONV;
          n.bias = 1'b1;
          n.conv = 1'b1;
          n.ss   = 1'b1;
          n.dcnt = 19'(P_DISCHG_CYC);
        end
      end
      ST_CONV: begin
        if (r.tmr == 23'(SS_CYC - 1)) begin
          n.st = ST_RUN;
          n.ss = 1'b0;
        end
      end
      ST_RUN: begin
        if (r.ctl.force_source_detect && r.ctl.host_mode) begin
          n.forced = 1'b1;
          n.ran    = 1'b1;
          n.st     = ST_VDET;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (vb && r.f.vbus_ov && r.st != ST_IDLE && r.st != ST_HIZ) begin
      n.st = ST_OVW;
    end
    if (r.ctl.high_impedance_enable && r.st != ST_IDLE) begin
      n.st = ST_HIZ;
    end
    if (!vb) begin
      n.st     = ST_IDLE;
      n.fails  = '0;
      n.vstat  = STAT_NONE;
      n.forced = 1'b0;
    end
    if (n.st != r.st) begin
      n.tmr = '0;
    end
    off_st = (n.st == ST_IDLE) || (n.st == ST_QUAL) ||
             (n.st == ST_OVW) || (n.st == ST_HIZ);
    if (off_st) begin
      n.bias = 1'b0;
      n.conv = 1'b0;
      n.ss   = 1'b0;
      n.pg   = 1'b0;
      n.dcnt = '0;
    end
    if (r.icnt != '0) begin
      n.icnt = r.icnt - 5'h1;
    end
    if (r.dcnt != '0) begin
      n.dcnt = r.dcnt - 19'h1;
    end
    n.batsw  = r.conv ? r.ctl.charge_enable : r.f.bat_ok;
    n.bsload = (n.st == ST_QUAL);
    n.disld  = (r.dcnt != '0) || r.ctl.battery_discharge_enable;
    n.pskip  = r.conv && r.f.light_load && !r.ctl.pulse_skip_disable &&
               (!r.ctl.charge_enable || r.f.bat_below_sysmin);
    n.afl    = n.pskip && !r.ctl.audible_floor_disable;
    n.apilim = imin(r.external_current_limit_pin, r.f.ext_external_current_limit_pin);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r      <= '0;
      r.st   <= ST_IDLE;
      r.ctl  <= CTRL_RST;
      r.external_current_limit_pin <= EXTERNAL_CURRENT_LIMIT_PIN_RST;
      r.vlim <= VLIM_RST;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // outputs
  assign s_axi_awready         = !r.awh && !r.bv;
  assign s_axi_wready          = !r.wh && !r.bv;
  assign s_axi_bvalid          = r.bv;
  assign s_axi_bresp           = r.bresp;
  assign s_axi_arready         = !r.rv;
  assign s_axi_rvalid          = r.rv;
  assign s_axi_rdata           = r.rd;
  assign s_axi_rresp           = r.rresp;
  assign battery_switch_on     = r.batsw;
  assign bias_regulator_en     = r.bias;
  assign converter_en          = r.conv;
  assign soft_start            = r.ss;
  assign bad_source_load_en    = r.bsload;
  assign discharge_load_en     = r.disld;
  assign pulse_skip_en         = r.pskip;
  assign audible_floor_en      = r.afl;
  assign applied_current_limit = r.apilim;
  assign source_type_status    = r.vstat;
  assign power_good_pin_n      = !r.pg;
  assign interrupt_pulse_pin_n = (r.icnt == '0);

  // ==========================================================================
  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_order;
    $rose(converter_en) |-> bias_regulator_en && $past(r.st == ST_BIAS);
  endproperty
  a_order: assert property (p_order) else $error("converter before bias");

  property p_qual_pass;
    r.st == ST_QUAL && !r.f.vbus_bad && r.f.vbus_present && !r.f.vbus_ov &&
    !r.ctl.high_impedance_enable && r.tmr == 23'(P_BAD_SRC_CYC - 1)
    |=> r.st == ST_VDET || r.st == ST_DONE;
  endproperty
  a_qual_pass: assert property (p_qual_pass) else $error("qual end");

  property p_ov_retry;
    r.st == ST_OVW && !r.f.vbus_ov && r.f.vbus_present &&
    !r.ctl.high_impedance_enable |=> r.st == ST_QUAL ##0 bad_source_load_en;
  endproperty
  a_ov_retry: assert property (p_ov_retry) else $error("no ov retry");

  property p_hiz7;
    r.st == ST_QUAL && r.f.vbus_bad && r.f.vbus_present && !r.f.vbus_ov &&
    r.fails == 3'h6 |=> r.st == ST_HIZ && !converter_en;
  endproperty
  a_hiz7: assert property (p_hiz7) else $error("no hiz after 7");

  property p_det_gate;
    $rose(r.st == ST_VDET) |-> $past(r.ctl.auto_source_detect_enable) ||
                               $past(r.st == ST_RUN);
  endproperty
  a_det_gate: assert property (p_det_gate) else $error("detect gated");

  property p_done;
    r.st == ST_DONE && r.f.vbus_present |=> !power_good_pin_n &&
      $fell(interrupt_pulse_pin_n) && r.pgf;
  endproperty
  a_done: assert property (p_done) else $error("done effects");

  property p_external_current_limit_pin;
    1'b1 |=> applied_current_limit == imin($past(r.external_current_limit_pin), $past(r.f.ext_external_current_limit_pin));
  endproperty
  a_external_current_limit_pin: assert property (p_external_current_limit_pin) else $error("limit not min");

  property p_skip;
    r.st == ST_DONE && !r.ran && !wr |=> r.external_current_limit_pin == $past(r.external_current_limit_pin);
  endproperty
  a_skip: assert property (p_skip) else $error("limit changed");

  property p_force_clr;
    r.st == ST_DONE && !wr_ctrl |=> !r.ctl.force_source_detect;
  endproperty
  a_force_clr: assert property (p_force_clr) else $error("force kept");

  property p_dis;
    $rose(converter_en) |=> discharge_load_en [*8];
  endproperty
  a_dis: assert property (p_dis) else $error("no discharge load");

  property p_pulse;
    $fell(interrupt_pulse_pin_n) |-> !interrupt_pulse_pin_n [*8] ##13
      interrupt_pulse_pin_n;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse length");

  c_hiz:   cover property (r.st == ST_HIZ);
  c_dcp:   cover property (r.st == ST_DONE && r.rstat == STAT_DCP);
  c_force: cover property (r.st == ST_DONE && r.forced);
  c_run:   cover property (r.st == ST_RUN && pulse_skip_en);

endmodule
`default_nettype wire

// File: verification/ips_adapter.sv
// model: usb adapter and battery pins seen by the sequencer
`timescale 1ns/1ns
`default_nettype none
module ips_adapter
  import ips_pkg::*;
(
  input  wire logic       plug,
  input  wire logic [2:0] kind,
  input  wire logic       bad,
  input  wire logic       ov,
  input  wire logic [4:0] ext,
  input  wire logic       bat_ok,
  input  wire logic       ll,
  input  wire logic       bl,
  output var  ips_pin_s   pins
);
  // ==========================================================================
  // line windows per adapter kind, released lines read low
  always_comb begin
    pins                  = '0;
    pins.ext_external_current_limit_pin         = ext;
    pins.bat_ok           = bat_ok;
    pins.light_load       = ll;
    pins.bat_below_sysmin = bl;
    if (plug) begin
      pins.vbus_present = 1'b1;
      pins.vbus_ov      = ov;
      pins.vbus_bad     = bad;
      case (kind)
        3'h0: pins.dcd_ok = 1'b1;
        3'h1: begin
          pins.dcd_ok  = 1'b1;
          pins.pri_hit = 1'b1;
        end
        3'h2: begin
          pins.dcd_ok  = 1'b1;
          pins.pri_hit = 1'b1;
          pins.sec_dcp = 1'b1;
        end
        3'h3: begin
          pins.dp_hi = 1'b1;
          pins.dm_hi = 1'b1;
        end
        3'h4: begin
          pins.dp_hi  = 1'b1;
          pins.dm_mid = 1'b1;
        end
        3'h5: begin
          pins.dp_mid = 1'b1;
          pins.dm_hi  = 1'b1;
        end
        3'h6: begin
          pins.dp_pull_low = 1'b1;
          pins.dm_3v3      = 1'b1;
        end
        default: pins.dcd_ok = 1'b0;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// testbench: register bus, detection table and power-up sequence
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import ips_pkg::*;
;
  typedef struct packed {
    logic [2:0] k;
    logic [8:0] c;
    logic [4:0] e;
    logic [4:0] il;
    logic [2:0] st;
  } ips_row_s;
  localparam int P_BAD = 50;
  localparam int P_BIA = 60;
  localparam int P_DIS = 30;
  localparam int LIMIT = 40000;
  localparam ips_row_s ROWS [11] = '{
    '{3'h0, 9'h086, 5'h1f, EXTERNAL_CURRENT_LIMIT_PIN_0P5A, STAT_SDP},
    '{3'h1, 9'h086, 5'h1f, EXTERNAL_CURRENT_LIMIT_PIN_1P5A, STAT_CDP},
    '{3'h2, 9'h086, 5'h1f, EXTERNAL_CURRENT_LIMIT_PIN_3P0A, STAT_DCP},
    '{3'h3, 9'h086, 5'h1f, EXTERNAL_CURRENT_LIMIT_PIN_2P4A, STAT_DIV},
    '{3'h4, 9'h086, 5'h1f, EXTERNAL_CURRENT_LIMIT_PIN_2P1A, STAT_DIV},
    '{3'h5, 9'h086, 5'h1f, EXTERNAL_CURRENT_LIMIT_PIN_1P0A, STAT_DIV},
    '{3'h6, 9'h086, 5'h1f, EXTERNAL_CURRENT_LIMIT_PIN_1P0A, STAT_UNK},
    '{3'h7, 9'h086, 5'h1f, EXTERNAL_CURRENT_LIMIT_PIN_0P5A, STAT_UNK},
    '{3'h2, 9'h086, 5'h0c, EXTERNAL_CURRENT_LIMIT_PIN_3P0A, STAT_DCP},
    '{3'h2, 9'h082, 5'h1f, EXTERNAL_CURRENT_LIMIT_PIN_3P0A, STAT_DCP},
    '{3'h2, 9'h084, 5'h1f, 5'h03,     STAT_NONE}
  };
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, r;
  logic        bsw, bias, conv, ss, bsl, dis, psk, afl, pgn, intn;
  logic [4:0]  lim, ext;
  logic [2:0]  stat, kind;
  logic        plug, bad, ov, bat_ok, ll, bl, e;
  ips_pin_s    pins;
  int          fail_count, samples_checked, cyc, n;

  ips_seq #(.P_BAD_SRC_CYC(P_BAD), .P_BIAS_CYC(P_BIA), .P_DISCHG_CYC(P_DIS))
  u_ips_seq (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pins(pins),
    .battery_switch_on(bsw), .bias_regulator_en(bias),
    .converter_en(conv), .soft_start(ss), .bad_source_load_en(bsl),
    .discharge_load_en(dis), .pulse_skip_en(psk),
    .audible_floor_en(afl), .applied_current_limit(lim),
    .source_type_status(stat), .power_good_pin_n(pgn),
    .interrupt_pulse_pin_n(intn));
  ips_adapter u_ips_adapter (.plug(plug), .kind(kind), .bad(bad),
    .ov(ov), .ext(ext), .bat_ok(bat_ok), .ll(ll), .bl(bl), .pins(pins));

  // ==========================================================================
  // clock, timeout and verdict
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task close_out;
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count = fail_count + 1;
      close_out;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked = samples_checked + 1;
    if (g !== x) begin
      fail_count = fail_count + 1;
      $display("Error at %0t got %h expected %h", $time, g, x);
    end
  endtask

  // ==========================================================================
  // bus master, interrupt wait and detection row tasks
  task axw(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask
  task axr(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask
  task wst(input logic [11:0] s);
    do axr(STAT_OFS); while (d[19:8] !== s);
  endtask
  task wint;
    while (intn) @(posedge aclk);
    n = 0;
    while (!intn) begin
      n = n + 1;
      @(posedge aclk);
    end
    chk(n, INT_CYC);
  endtask
  task run_row(input ips_row_s w);
    logic [4:0] m;
    logic [4:0] vl;
    m  = (w.il < w.e) ? w.il : w.e;
    vl = (w.c[2] && w.c[1]) ? VLIM_RST : 5'h0a;
    axw(CTRL_OFS, {23'h0, w.c});
    axw(LIM_OFS, 32'h0a03);
    kind <= w.k;
    ext  <= w.e;
    plug <= 1'b1;
    wint;
    chk(pgn, 1'b0);
    chk(stat, w.st);
    chk(lim, m);
    axr(LIM_OFS);
    chk(d, {19'h0, vl, 3'h0, w.il});
    axr(STAT_OFS);
    chk(d[4:0], {2'b11, w.st});
    plug <= 1'b0;
    while (!pgn) @(posedge aclk);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {plug, bad, ov, ll, bl, kind, fail_count, samples_checked, cyc} = '0;
    bat_ok = 1'b1;
    ext    = 5'h1f;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(CTRL_OFS);
    chk(d, {23'h0, CTRL_RST});
    axr(LIM_OFS);
    chk(d, 32'h0605);
    chk(bsw, 1'b1);
    chk(bias, 1'b0);
    axr(8'h0c);
    chk(r, RESP_DECERR);
    chk(d, 32'h0);
    axw(8'h40, 32'h1);
    chk(r, RESP_DECERR);
    foreach (ROWS[i]) run_row(ROWS[i]);
    axw(CTRL_OFS, 32'h086);
    kind <= 3'h2;
    plug <= 1'b1;
    while (!bsl) @(posedge aclk);
    n = 0;
    while (bsl) begin
      n = n + 1;
      @(posedge aclk);
    end
    chk(n, P_BAD);
    wint;
    n = 0;
    e = 1'b0;
    while (!bias) begin
      if (conv !== 1'b0) e = 1'b1;
      n = n + 1;
      @(posedge aclk);
    end
    chk(e, 1'b0);
    chk(n + INT_CYC, P_BIA);
    while (!dis) @(posedge aclk);
    n = 0;
    while (dis) begin
      n = n + 1;
      @(posedge aclk);
    end
    chk(n, P_DIS);
    chk(ss, 1'b1);
    wst(12'h800);
    chk({conv, bsw, ss}, 3'b110);
    ll <= 1'b1;
    bl <= 1'b1;
    while (!psk) @(posedge aclk);
    chk(afl, 1'b1);
    axw(CTRL_OFS, 32'h006);
    bl <= 1'b0;
    while (bsw) @(posedge aclk);
    repeat (6) @(posedge aclk);
    chk(psk, 1'b1);
    axw(CTRL_OFS, 32'h046);
    repeat (4) @(posedge aclk);
    chk({psk, afl}, 2'b10);
    axw(CTRL_OFS, 32'h026);
    while (psk) @(posedge aclk);
    axw(CTRL_OFS, 32'h016);
    while (!dis) @(posedge aclk);
    axw(CTRL_OFS, 32'h10e);
    wint;
    axr(CTRL_OFS);
    chk(d, 32'h106);
    plug <= 1'b0;
    while (!pgn) @(posedge aclk);
    axw(CTRL_OFS, 32'h087);
    bad  <= 1'b1;
    plug <= 1'b1;
    wst(12'h008);
    axr(CTRL_OFS);
    chk(d[0], 1'b0);
    axr(STAT_OFS);
    chk(d[7:5], 3'h0);
    chk({bias, pgn}, 2'b01);
    bad <= 1'b0;
    axw(CTRL_OFS, 32'h087);
    axw(CTRL_OFS, 32'h086);
    wint;
    plug <= 1'b0;
    while (!pgn) @(posedge aclk);
    ov   <= 1'b1;
    plug <= 1'b1;
    wst(12'h004);
    ov <= 1'b0;
    wint;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axr(LIM_OFS);
    chk(d, 32'h0605);
    chk(pgn, 1'b1);
    close_out;
  end
endmodule
`default_nettype wire
